//--- verilog/vmc_vendor_cfg.sv
// Vendor mode configuration register of the PHY with its control outputs.
// Behaviour
// [R1] Register at 0x10, resets to 0x0140.
// [R2] Auto-polarity disable stops automatic polarity correction.
// [R3] 10BASE-T negotiation detects reversed pair, inverts.
// [R4] Polarity bit reports auto inversion, ignores writes.
// [R5] Polarity bit forces inversion when auto disabled.
// [R6] Bypass bit skips coding sublayer and scrambler.
// [R7] Software sets bypass only in forced 100BASE-TX.
// [R8] Clock gating stops idle receive clock in 100BASE-TX.
// [R9] Loopback always suppresses receive clock gating.
// [R10] Software avoids clock gating together with bypass.
// [R11] Software preserves reserved bits on read-modify-write.
// [R12] Interrupt polarity bit selects active high or low.
// [R13] Status bits clear on read, enables gate interrupt.
`timescale 1ns/100ps
`default_nettype none
`include "vmc_defs.svh"
module vmc_vendor_cfg (
    input  wire logic               clk_sys_i,          // 20 MHz clock.
    input  wire logic               rstn_i,             // Async reset, low.
    input  wire vmc_pkg::vmc_addr_t mgmt_addr_i,        // Register address.
    input  wire logic               mgmt_wr_i,          // Write strobe.
    input  wire logic               mgmt_rd_i,          // Read strobe.
    input  wire vmc_pkg::vmc_word_t mgmt_wdata_i,       // Write data.
    output var  vmc_pkg::vmc_word_t mgmt_rdata_o,       // Read data.
    output logic                    mgmt_rvalid_o,      // Read data valid.
    input  wire logic               mode_10bt_i,        // Link in 10BASE-T.
    input  wire logic               mode_100tx_i,       // Link in 100BASE-TX.
    input  wire logic               aneg_active_i,      // Negotiation running.
    input  wire logic               rx_pair_reversed_i, // Reversed pair seen.
    input  wire logic               rx_data_active_i,   // Receive data present.
    input  wire logic               loopback_ctl_i,     // Basic control loop.
    input  wire vmc_pkg::vmc_byte_t phy_events_i,       // Interrupt events.
    output logic                    rx_invert_o,        // Invert rx pulses.
    output logic                    coding_sublayer_bypass_o, // Skip PCS.
    output logic                    rx_clk_stop_o,      // Stop rx clock.
    output logic                    tx_high_impedance_o,      // Tx pins off.
    output logic                    heartbeat_test_inhibit_o, // No SQE test.
    output logic                    natural_loopback_10m_o,   // 10M loop.
    output logic                    repeater_mode_sel_o,      // Repeater.
    output logic                    phy_irq_o           // PHY interrupt.
);
    import vmc_pkg::*;

    logic           repeater_mode_sel;
    logic           irq_polarity;
    logic           tx_high_impedance;
    logic           heartbeat_test_inhibit;
    logic           natural_loopback_10m;
    logic           auto_polarity_disable;
    logic           rx_polarity_forced;
    logic           coding_sublayer_bypass;
    logic           rx_clock_gating;
    vmc_pol_state_t pol_state;
    vmc_word_t      cfg_word;
    vmc_byte_t      irq_status;
    vmc_byte_t      irq_enable;
    logic           irq_pending;
    logic           cfg_wr;
    logic           irq_wr;
    logic           irq_rd;
    logic           auto_inverting;

    function automatic logic addr_hit(input vmc_addr_t a,
                                      input vmc_addr_t b);
        addr_hit = (a == b);
    endfunction

    assign cfg_wr = mgmt_wr_i && addr_hit(mgmt_addr_i, `VMC_ADDR_CFG);
    assign irq_wr = mgmt_wr_i && addr_hit(mgmt_addr_i, `VMC_ADDR_IRQ);
    assign irq_rd = mgmt_rd_i && addr_hit(mgmt_addr_i, `VMC_ADDR_IRQ);
    assign auto_inverting = (pol_state == VMC_POL_INVERTED);

    // Reserved fields are constants, so reads return their fixed values.
    always_comb begin
        cfg_word = `VMC_CFG_FIXED_VAL; // [R1]
        cfg_word[`VMC_BIT_REPEATER]   = repeater_mode_sel;
        cfg_word[`VMC_BIT_IRQ_POL]    = irq_polarity;
        cfg_word[`VMC_BIT_TX_HIZ]     = tx_high_impedance;
        cfg_word[`VMC_BIT_HB_INHIBIT] = heartbeat_test_inhibit;
        cfg_word[`VMC_BIT_NAT_LOOP]   = natural_loopback_10m;
        cfg_word[`VMC_BIT_APD]        = auto_polarity_disable;
        cfg_word[`VMC_BIT_RX_POL]     = auto_polarity_disable ?
                                        rx_polarity_forced :
                                        auto_inverting; // [R4]
        cfg_word[`VMC_BIT_BYPASS]     = coding_sublayer_bypass;
        cfg_word[`VMC_BIT_RXCLK_GATE] = rx_clock_gating;
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            repeater_mode_sel      <= 1'b0; // [R1]
            irq_polarity           <= 1'b0;
            tx_high_impedance      <= 1'b0;
            heartbeat_test_inhibit <= 1'b0;
            natural_loopback_10m   <= 1'b0;
            auto_polarity_disable  <= 1'b0;
            coding_sublayer_bypass <= 1'b0;
            rx_clock_gating        <= 1'b0;
        end else if (cfg_wr) begin
            repeater_mode_sel      <= mgmt_wdata_i[`VMC_BIT_REPEATER];
            irq_polarity           <= mgmt_wdata_i[`VMC_BIT_IRQ_POL];
            tx_high_impedance      <= mgmt_wdata_i[`VMC_BIT_TX_HIZ];
            heartbeat_test_inhibit <= mgmt_wdata_i[`VMC_BIT_HB_INHIBIT];
            natural_loopback_10m   <= mgmt_wdata_i[`VMC_BIT_NAT_LOOP];
            auto_polarity_disable  <= mgmt_wdata_i[`VMC_BIT_APD];
            coding_sublayer_bypass <= mgmt_wdata_i[`VMC_BIT_BYPASS];
            rx_clock_gating        <= mgmt_wdata_i[`VMC_BIT_RXCLK_GATE];
        end
    end

    // The forced polarity is taken only when the same write leaves
    // automatic correction disabled; otherwise the bit is read-only.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_polarity_forced <= 1'b0;
        end else if (cfg_wr && mgmt_wdata_i[`VMC_BIT_APD]) begin
            rx_polarity_forced <= mgmt_wdata_i[`VMC_BIT_RX_POL]; // [R5]
        end
    end

    // Automatic polarity tracks the pair only during 10BASE-T negotiation.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pol_state <= VMC_POL_NORMAL;
        end else if (auto_polarity_disable) begin
            pol_state <= VMC_POL_NORMAL; // [R2]
        end else if (mode_10bt_i && aneg_active_i) begin
            case (pol_state)
                VMC_POL_NORMAL: begin
                    if (rx_pair_reversed_i) begin
                        pol_state <= VMC_POL_INVERTED; // [R3]
                    end
                end
                VMC_POL_INVERTED: begin
                    if (!rx_pair_reversed_i) begin
                        pol_state <= VMC_POL_NORMAL; // [R3]
                    end
                end
                default: begin
                    pol_state <= VMC_POL_NORMAL;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_invert_o <= 1'b0;
        end else begin
            rx_invert_o <= cfg_word[`VMC_BIT_RX_POL]; // [R4] [R5]
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            coding_sublayer_bypass_o <= 1'b0;
        end else begin
            coding_sublayer_bypass_o <= coding_sublayer_bypass &&
                                        mode_100tx_i; // [R6]
        end
    end

    // Loopback needs a running receive clock, so it overrides gating.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_clk_stop_o <= 1'b0;
        end else begin
            rx_clk_stop_o <= rx_clock_gating && mode_100tx_i &&
                             !rx_data_active_i &&
                             !loopback_ctl_i; // [R8] [R9]
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_high_impedance_o      <= 1'b0;
            heartbeat_test_inhibit_o <= 1'b0;
            natural_loopback_10m_o   <= 1'b0;
            repeater_mode_sel_o      <= 1'b0;
        end else begin
            tx_high_impedance_o      <= tx_high_impedance;
            heartbeat_test_inhibit_o <= heartbeat_test_inhibit;
            natural_loopback_10m_o   <= natural_loopback_10m;
            repeater_mode_sel_o      <= repeater_mode_sel;
        end
    end

    vmc_irq_ctl u_irq_ctl (
        .clk_sys_i    (clk_sys_i),
        .rstn_i       (rstn_i),
        .event_i      (phy_events_i),
        .en_wr_i      (irq_wr),
        .en_wdata_i   (mgmt_wdata_i[15:8]),
        .status_clr_i (irq_rd),
        .status_o     (irq_status),
        .enable_o     (irq_enable),
        .pending_o    (irq_pending)
    );

    // Reset leaves the polarity low, so the idle output is high.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phy_irq_o <= 1'b1;
        end else begin
            phy_irq_o <= irq_polarity ? irq_pending : !irq_pending; // [R12]
        end
    end

    // Other management addresses belong to other registers and read zero.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mgmt_rdata_o  <= 16'h0000;
            mgmt_rvalid_o <= 1'b0;
        end else begin
            mgmt_rvalid_o <= mgmt_rd_i;
            if (mgmt_rd_i) begin
                if (addr_hit(mgmt_addr_i, `VMC_ADDR_CFG)) begin
                    mgmt_rdata_o <= cfg_word; // [R1]
                end else if (irq_rd) begin
                    mgmt_rdata_o <= {irq_enable, irq_status}; // [R13]
                end else begin
                    mgmt_rdata_o <= 16'h0000;
                end
            end
        end
    end

    sequence s_cfg_read;
        mgmt_rd_i && addr_hit(mgmt_addr_i, `VMC_ADDR_CFG);
    endsequence

    sequence s_force_write;
        cfg_wr && mgmt_wdata_i[`VMC_BIT_APD] ##1 !cfg_wr;
    endsequence

    a_reset_value: assert property ( // [R1]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        $rose(rstn_i) |-> cfg_word == `VMC_CFG_RESET)
        else $error("register not at reset value");

    a_fixed_bits: assert property ( // [R1]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        s_cfg_read |=> mgmt_rvalid_o &&
        ((mgmt_rdata_o & `VMC_CFG_FIXED_MASK) == `VMC_CFG_FIXED_VAL))
        else $error("reserved bits read wrong");

    a_apd_stops: assert property ( // [R2]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        auto_polarity_disable |=> pol_state == VMC_POL_NORMAL)
        else $error("auto polarity ran while disabled");

    a_auto_detect: assert property ( // [R3]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !auto_polarity_disable && mode_10bt_i && aneg_active_i &&
        rx_pair_reversed_i ##1 !auto_polarity_disable |=> rx_invert_o)
        else $error("reversed pair not inverted");

    a_pol_report: assert property ( // [R4]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        !auto_polarity_disable and s_cfg_read |=>
        mgmt_rdata_o[`VMC_BIT_RX_POL] == $past(auto_inverting))
        else $error("polarity bit does not report auto state");

    a_pol_force: assert property ( // [R5]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        s_force_write |=> rx_invert_o == $past(mgmt_wdata_i[4], 2))
        else $error("forced polarity not applied");

    a_bypass_out: assert property ( // [R6]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        coding_sublayer_bypass && mode_100tx_i |=> coding_sublayer_bypass_o)
        else $error("coding sublayer bypass not driven");

    a_rxclk_stop: assert property ( // [R8]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        rx_clock_gating && mode_100tx_i && !rx_data_active_i &&
        !loopback_ctl_i |=> rx_clk_stop_o)
        else $error("idle receive clock not stopped");

    a_loop_guard: assert property ( // [R9]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        loopback_ctl_i |=> !rx_clk_stop_o)
        else $error("receive clock gated in loopback");

    a_irq_level: assert property ( // [R12]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        irq_pending |=> phy_irq_o == $past(irq_polarity))
        else $error("interrupt level wrong for polarity");
endmodule
`default_nettype wire

//--- verilog/vmc_defs.svh
// Offsets, field positions and reset values of the vendor mode register.
`ifndef VMC_DEFS_SVH
`define VMC_DEFS_SVH

`define VMC_ADDR_W          5
`define VMC_ADDR_CFG        5'h10
`define VMC_ADDR_IRQ        5'h11

`define VMC_CFG_RESET       16'h0140
`define VMC_CFG_FIXED_MASK  16'h23CC
`define VMC_CFG_FIXED_VAL   16'h0140

`define VMC_BIT_REPEATER    15
`define VMC_BIT_IRQ_POL     14
`define VMC_BIT_TX_HIZ      12
`define VMC_BIT_HB_INHIBIT  11
`define VMC_BIT_NAT_LOOP    10
`define VMC_BIT_APD         5
`define VMC_BIT_RX_POL      4
`define VMC_BIT_BYPASS      1
`define VMC_BIT_RXCLK_GATE  0

`define VMC_IRQ_STATUS_RESET 8'h00
`define VMC_IRQ_ENABLE_RESET 8'h00

`endif

//--- verilog/vmc_pkg.sv
// Types shared by the vendor mode register block.
package vmc_pkg;
    typedef logic [15:0] vmc_word_t;
    typedef logic [7:0]  vmc_byte_t;
    typedef logic [4:0]  vmc_addr_t;
    typedef enum logic [0:0] {
        VMC_POL_NORMAL   = 1'b0,
        VMC_POL_INVERTED = 1'b1
    } vmc_pol_state_t;
endpackage

//--- verilog/vmc_irq_ctl.sv
// PHY interrupt status and enable bits with clear on read.
`timescale 1ns/100ps
`default_nettype none
`include "vmc_defs.svh"
module vmc_irq_ctl (
    input  wire logic               clk_sys_i,    // System clock.
    input  wire logic               rstn_i,       // Asynchronous reset, low.
    input  wire vmc_pkg::vmc_byte_t event_i,      // One-cycle event pulses.
    input  wire logic               en_wr_i,      // Write strobe for enables.
    input  wire vmc_pkg::vmc_byte_t en_wdata_i,   // New enable bits.
    input  wire logic               status_clr_i, // Status read strobe.
    output var  vmc_pkg::vmc_byte_t status_o,     // Sticky event bits.
    output var  vmc_pkg::vmc_byte_t enable_o,     // Enable bits.
    output logic                    pending_o     // Any enabled event set.
);
    import vmc_pkg::*;

    wire vmc_byte_t next_status;

    // A new event in the read cycle survives the clear.
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_status
            assign next_status[k] = event_i[k]   ? 1'b1 :
                                    status_clr_i ? 1'b0 :
                                    status_o[k]; // [R13]
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_o <= `VMC_IRQ_STATUS_RESET;
        end else begin
            status_o <= next_status; // [R13]
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            enable_o <= `VMC_IRQ_ENABLE_RESET;
        end else if (en_wr_i) begin
            enable_o <= en_wdata_i;
        end
    end

    assign pending_o = |(status_o & enable_o); // [R13]

    a_event_sets: assert property ( // [R13]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        |event_i |=> ((status_o & $past(event_i)) == $past(event_i)))
        else $error("event did not set its status bit");

    a_read_clears: assert property ( // [R13]
        @(posedge clk_sys_i) disable iff (!rstn_i)
        status_clr_i && (event_i == 8'h00) |=> status_o == 8'h00)
        else $error("status bits not cleared by read");
endmodule
`default_nettype wire

//--- test/vmc_vendor_cfg_bench.sv
// Self-checking bench for the vendor mode configuration register block.
`timescale 1ns/100ps
`default_nettype none
`include "vmc_defs.svh"
module vmc_vendor_cfg_bench;
    import vmc_pkg::*;

    logic       clk_sys_i;
    logic       rstn_i;
    vmc_addr_t  mgmt_addr_i;
    logic       mgmt_wr_i;
    logic       mgmt_rd_i;
    vmc_word_t  mgmt_wdata_i;
    vmc_word_t  mgmt_rdata_o;
    logic       mgmt_rvalid_o;
    logic       mode_10bt_i;
    logic       mode_100tx_i;
    logic       aneg_active_i;
    logic       rx_pair_reversed_i;
    logic       rx_data_active_i;
    logic       loopback_ctl_i;
    vmc_byte_t  phy_events_i;
    logic       rx_invert_o;
    logic       coding_sublayer_bypass_o;
    logic       rx_clk_stop_o;
    logic       tx_high_impedance_o;
    logic       heartbeat_test_inhibit_o;
    logic       natural_loopback_10m_o;
    logic       repeater_mode_sel_o;
    logic       phy_irq_o;
    vmc_word_t  outs;
    int         error_cnt;
    int         n_compared;

    // Control outputs gathered: rep, hiz, hb, nat, inv, bypass, clk stop.
    assign outs = {9'h000, repeater_mode_sel_o, tx_high_impedance_o,
                   heartbeat_test_inhibit_o, natural_loopback_10m_o,
                   rx_invert_o, coding_sublayer_bypass_o, rx_clk_stop_o};

    vmc_vendor_cfg uut (
        .clk_sys_i                (clk_sys_i),
        .rstn_i                   (rstn_i),
        .mgmt_addr_i              (mgmt_addr_i),
        .mgmt_wr_i                (mgmt_wr_i),
        .mgmt_rd_i                (mgmt_rd_i),
        .mgmt_wdata_i             (mgmt_wdata_i),
        .mgmt_rdata_o             (mgmt_rdata_o),
        .mgmt_rvalid_o            (mgmt_rvalid_o),
        .mode_10bt_i              (mode_10bt_i),
        .mode_100tx_i             (mode_100tx_i),
        .aneg_active_i            (aneg_active_i),
        .rx_pair_reversed_i       (rx_pair_reversed_i),
        .rx_data_active_i         (rx_data_active_i),
        .loopback_ctl_i           (loopback_ctl_i),
        .phy_events_i             (phy_events_i),
        .rx_invert_o              (rx_invert_o),
        .coding_sublayer_bypass_o (coding_sublayer_bypass_o),
        .rx_clk_stop_o            (rx_clk_stop_o),
        .tx_high_impedance_o      (tx_high_impedance_o),
        .heartbeat_test_inhibit_o (heartbeat_test_inhibit_o),
        .natural_loopback_10m_o   (natural_loopback_10m_o),
        .repeater_mode_sel_o      (repeater_mode_sel_o),
        .phy_irq_o                (phy_irq_o)
    );

    initial clk_sys_i = 1'b0;
    always #25 clk_sys_i = ~clk_sys_i;

    task automatic conclude();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input vmc_word_t got, input vmc_word_t exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Every task starts and ends just after a rising edge.
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            #2;
        end
    endtask

    task automatic wr(input vmc_addr_t a, input vmc_word_t d);
        mgmt_addr_i  = a;
        mgmt_wdata_i = d;
        mgmt_wr_i    = 1'b1;
        step(1);
        mgmt_wr_i    = 1'b0;
        // An idle cycle keeps back-to-back calls from re-raising a strobe.
        step(1);
    endtask

    task automatic rd(input vmc_addr_t a, input vmc_word_t exp);
        mgmt_addr_i = a;
        mgmt_rd_i   = 1'b1;
        step(1);
        mgmt_rd_i   = 1'b0;
        chk({15'h0000, mgmt_rvalid_o}, 16'h0001);
        chk(mgmt_rdata_o, exp);
        step(1);
    endtask

    // One-cycle event pulse, then time for the interrupt to settle.
    task automatic ev(input vmc_byte_t e);
        phy_events_i = e;
        step(1);
        phy_events_i = 8'h00;
        step(2);
    endtask

    task automatic irq_is(input logic v);
        chk({15'h0000, phy_irq_o}, {15'h0000, v});
    endtask

    initial begin
        #100000;
        error_cnt++;
        conclude();
    end

    initial begin
        error_cnt = 0;
        n_compared = 0;
        rstn_i = 1'b0;
        mgmt_addr_i = 5'h00;
        mgmt_wr_i = 1'b0;
        mgmt_rd_i = 1'b0;
        mgmt_wdata_i = 16'h0000;
        {mode_10bt_i, mode_100tx_i, aneg_active_i} = 3'h0;
        {rx_pair_reversed_i, rx_data_active_i, loopback_ctl_i} = 3'h0;
        phy_events_i = 8'h00;
        step(6);
        rstn_i = 1'b1;
        step(1);
        rd(`VMC_ADDR_CFG, 16'h0140);
        rd(`VMC_ADDR_IRQ, 16'h0000);
        irq_is(1'b1);
        wr(5'h05, 16'hFFFF);
        rd(5'h05, 16'h0000);
        rd(`VMC_ADDR_CFG, 16'h0140);
        // Every write keeps the reserved bits as they read back.
        mode_100tx_i = 1'b1;
        wr(`VMC_ADDR_CFG, 16'hDD72);
        step(2);
        rd(`VMC_ADDR_CFG, 16'hDD72);
        chk(outs, 16'h007E);
        irq_is(1'b0);
        mode_100tx_i = 1'b0;
        step(2);
        chk(outs, 16'h007C);
        // Clock gating is enabled only once the bypass is off again.
        mode_100tx_i = 1'b1;
        wr(`VMC_ADDR_CFG, 16'hDD71);
        step(2);
        chk(outs, 16'h007D);
        loopback_ctl_i = 1'b1;
        step(2);
        chk(outs, 16'h007C);
        loopback_ctl_i = 1'b0;
        rx_data_active_i = 1'b1;
        step(2);
        chk(outs, 16'h007C);
        rx_data_active_i = 1'b0;
        mode_100tx_i = 1'b0;
        step(2);
        chk(outs, 16'h007C);
        wr(`VMC_ADDR_CFG, 16'h0160);
        step(2);
        chk(outs, 16'h0000);
        rd(`VMC_ADDR_CFG, 16'h0160);
        // Auto mode: polarity bit written high must be ignored.
        wr(`VMC_ADDR_CFG, 16'h0150);
        step(2);
        rd(`VMC_ADDR_CFG, 16'h0140);
        chk(outs, 16'h0000);
        mode_10bt_i = 1'b1;
        aneg_active_i = 1'b1;
        rx_pair_reversed_i = 1'b1;
        step(3);
        chk(outs, 16'h0004);
        rd(`VMC_ADDR_CFG, 16'h0150);
        wr(`VMC_ADDR_CFG, 16'h0160);
        step(2);
        chk(outs, 16'h0000);
        rd(`VMC_ADDR_CFG, 16'h0160);
        wr(`VMC_ADDR_CFG, 16'h0170);
        step(2);
        chk(outs, 16'h0004);
        {mode_10bt_i, aneg_active_i, rx_pair_reversed_i} = 3'h0;
        wr(`VMC_ADDR_CFG, 16'h0140);
        step(2);
        // Interrupt enables; the status byte cannot be written.
        wr(`VMC_ADDR_IRQ, 16'h01FF);
        rd(`VMC_ADDR_IRQ, 16'h0100);
        ev(8'h02);
        irq_is(1'b1);
        rd(`VMC_ADDR_IRQ, 16'h0102);
        rd(`VMC_ADDR_IRQ, 16'h0100);
        // An event in the reading cycle survives the clear.
        phy_events_i = 8'h04;
        rd(`VMC_ADDR_IRQ, 16'h0100);
        phy_events_i = 8'h00;
        rd(`VMC_ADDR_IRQ, 16'h0104);
        ev(8'h01);
        irq_is(1'b0);
        rd(`VMC_ADDR_IRQ, 16'h0101);
        step(2);
        irq_is(1'b1);
        wr(`VMC_ADDR_CFG, 16'h4140);
        step(2);
        irq_is(1'b0);
        ev(8'h01);
        irq_is(1'b1);
        rd(`VMC_ADDR_IRQ, 16'h0101);
        step(2);
        irq_is(1'b0);
        rd(`VMC_ADDR_CFG, 16'h4140);
        conclude();
    end
endmodule
`default_nettype wire
